//--- rtl/alx_core.sv
// alx_core: execution unit for add, and, call and clear with an apb slave
// ****************************************
// Functional notes
// ****************************************
// Functional notes
// - carry add to accumulator: acc+mem+carry into acc, four flags updated
// - carry add to memory: acc+mem+carry into memory byte, four flags
// - add memory to accumulator without carry, four flags updated
// - add immediate to accumulator without carry, four flags updated
// - add accumulator into memory byte, acc unchanged, four flags
// - and memory into accumulator, only the zero flag changes
// - and immediate into accumulator, only the zero flag changes
// - and accumulator into memory byte, only the zero flag changes
// - call pushes program counter plus one onto return stack
// - call then loads target address into program counter
// - call takes two cycles and leaves every flag unchanged
// - clear writes zero into the memory byte, flags untouched
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module alx_core
  import alx_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);

  // ****************************************
  // adder
  // ****************************************
  // returns {excess, half, carry, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    logic ov;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    ov = (a[7] == b[7]) && (full[7] != a[7]);
    return {ov, lo[4], full[8], full[7:0]};
  endfunction

  alx_state_t st_q;
  alx_state_t st_d;

  logic [7:0] mem_byte;
  logic [7:0] operand_b;
  logic carry_in;
  logic [10:0] sum_v;
  logic [7:0] and_v;
  logic bus_ok;
  logic bus_commit;
  logic is_dmem;
  logic [DMEM_AW-1:0] dmem_sel;

  assign mem_byte = st_q.dmem[st_q.idx];
  assign carry_in = (st_q.op == OP_ADC ||
                     st_q.op == OP_CARRY_SUM_INTO_MEMORY) ?
                    st_q.flags.msb_out_flag : 1'b0;
  assign operand_b = (st_q.op == OP_ADD_IMM || st_q.op == OP_AND_IMM) ?
                     st_q.arg[7:0] : mem_byte;
  assign sum_v = add8(st_q.acc, operand_b, carry_in);
  assign and_v = st_q.acc & operand_b;
  // bus access answered only while no instruction is in flight
  assign bus_ok = psel && penable && !st_q.rsp.pready &&
                  st_q.phase == PH_IDLE;
  // the write commits at the completion edge, with the request still held
  assign bus_commit = psel && penable && pwrite && st_q.rsp.pready;
  assign is_dmem = paddr >= ADDR_DMEM && paddr <= ADDR_DMEM_END &&
                   paddr[1:0] == 2'b00;
  assign dmem_sel = paddr[DMEM_AW+1:2];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.rsp.pready = 1'b0;
    st_d.rsp.pslverr = 1'b0;
    unique case (st_q.phase)
      PH_IDLE: begin
        // the answer is registered so pready comes from a flop; read data
        // and the error flag are fixed one edge before the master samples
        if (bus_ok) begin
          st_d.rsp.pready = 1'b1;
          st_d.rsp.prdata = '0;
          if (is_dmem) begin
            if (!pwrite) begin
              st_d.rsp.prdata = {24'h000000, st_q.dmem[dmem_sel]};
            end
          end else begin
            unique case (paddr)
              ADDR_EXEC: begin
                if (!pwrite) begin
                  st_d.rsp.prdata = {16'h0000, 4'h0, st_q.idx, 4'h0,
                                     st_q.op};
                end
              end
              ADDR_ACC: begin
                if (!pwrite) begin
                  st_d.rsp.prdata = {24'h000000, st_q.acc};
                end
              end
              ADDR_FLAGS: begin
                if (!pwrite) begin
                  st_d.rsp.prdata = {28'h0000000, st_q.flags};
                end
              end
              ADDR_PC: begin
                if (!pwrite) begin
                  st_d.rsp.prdata = {21'h0, st_q.pc};
                end
              end
              ADDR_STACK: begin
                // read only: top entry and pointer
                if (!pwrite) begin
                  st_d.rsp.prdata = {13'h0, st_q.sp, 5'h0,
                                     st_q.stack[st_q.sp - 3'h1]};
                end
              end
              default: begin
                st_d.rsp.pslverr = 1'b1;
              end
            endcase
          end
        end
        // a write lands only at the edge where the master sees pready high
        if (bus_commit) begin
          if (is_dmem) begin
            st_d.dmem[dmem_sel] = pwdata[7:0];
          end else begin
            unique case (paddr)
              ADDR_EXEC: begin
                st_d.op = alx_op_t'(pwdata[EXEC_OP_LSB +: 4]);
                st_d.idx = pwdata[EXEC_IDX_LSB +: DMEM_AW];
                st_d.arg = pwdata[EXEC_ARG_LSB +: PC_W];
                st_d.phase = PH_EXEC;
              end
              ADDR_ACC: begin
                st_d.acc = pwdata[7:0];
              end
              ADDR_FLAGS: begin
                st_d.flags = pwdata[3:0];
              end
              ADDR_PC: begin
                st_d.pc = pwdata[PC_W-1:0];
              end
              default: begin
              end
            endcase
          end
        end
      end
      PH_EXEC: begin
        st_d.phase = PH_IDLE;
        st_d.pc = st_q.pc + 11'h001;
        unique case (st_q.op)
          OP_ADC, OP_ADD, OP_ADD_IMM: begin
            st_d.acc = sum_v[7:0];
            st_d.flags = {sum_v[10], sum_v[7:0] == ZERO_BYTE, sum_v[9],
                          sum_v[8]};
          end
          OP_CARRY_SUM_INTO_MEMORY, OP_SUM_INTO_MEMORY: begin
            st_d.dmem[st_q.idx] = sum_v[7:0];
            st_d.flags = {sum_v[10], sum_v[7:0] == ZERO_BYTE, sum_v[9],
                          sum_v[8]};
          end
          OP_AND, OP_AND_IMM: begin
            st_d.acc = and_v;
            st_d.flags.result_null_flag = and_v == ZERO_BYTE;
          end
          OP_BITWISE_CONJUNCTION_TO_MEMORY: begin
            st_d.dmem[st_q.idx] = and_v;
            st_d.flags.result_null_flag = and_v == ZERO_BYTE;
          end
          OP_CALL: begin
            // the stack wraps when full, oldest entry is lost
            st_d.stack[st_q.sp] = st_q.pc + 11'h001;
            st_d.sp = st_q.sp + 3'h1;
            st_d.pc = st_q.pc;
            st_d.phase = PH_CALL2;
          end
          OP_ZERO_MEMORY_BYTE: begin
            st_d.dmem[st_q.idx] = ZERO_BYTE;
          end
          default: begin
          end
        endcase
      end
      PH_CALL2: begin
        st_d.pc = st_q.arg;
        st_d.phase = PH_IDLE;
      end
      default: begin
        st_d.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready = st_q.rsp.pready;
  assign pslverr = st_q.rsp.pslverr;
  assign prdata = st_q.rsp.prdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic in_exec;
  assign in_exec = st_q.phase == PH_EXEC;

  AST_ADC_ACC: assert property (
    in_exec && st_q.op == OP_ADC |=> st_q.acc ==
      8'($past(st_q.acc) + $past(mem_byte) + $past(st_q.flags.msb_out_flag))
  ) else $error("carry add result wrong");
  AST_CARRY_SUM_INTO_MEMORY_MEM: assert property (
    in_exec && st_q.op == OP_CARRY_SUM_INTO_MEMORY |=>
      st_q.dmem[$past(st_q.idx)] == 8'($past(st_q.acc) + $past(mem_byte) +
        $past(st_q.flags.msb_out_flag)) &&
      st_q.acc == $past(st_q.acc)
  ) else $error("carry sum into memory wrong");
  AST_ADD_CARRY: assert property (
    in_exec && st_q.op == OP_ADD |=> {st_q.flags.msb_out_flag, st_q.acc} ==
      9'({1'b0, $past(st_q.acc)} + {1'b0, $past(mem_byte)})
  ) else $error("add or carry flag wrong");
  AST_ADDI_HALF: assert property (
    in_exec && st_q.op == OP_ADD_IMM |=> st_q.flags.half_carry_flag ==
      ($past(st_q.acc[3:0]) + $past(st_q.arg[3:0]) > 5'd15)
  ) else $error("half carry wrong");
  AST_SUM_INTO_MEMORY_ACC: assert property (
    in_exec && st_q.op == OP_SUM_INTO_MEMORY |=> $stable(st_q.acc)
  ) else $error("sum into memory changed acc");
  AST_AND_FLAGS: assert property (
    in_exec && (st_q.op == OP_AND || st_q.op == OP_AND_IMM) |=>
      st_q.flags.msb_out_flag == $past(st_q.flags.msb_out_flag) &&
      st_q.flags.result_null_flag == (st_q.acc == ZERO_BYTE)
  ) else $error("and flags wrong");
  AST_BITWISE_CONJUNCTION_TO_MEMORY_MEM: assert property (
    in_exec && st_q.op == OP_BITWISE_CONJUNCTION_TO_MEMORY |=>
      st_q.dmem[$past(st_q.idx)] == ($past(st_q.acc) & $past(mem_byte))
  ) else $error("and to memory wrong");
  AST_CALL_SEQ: assert property (
    in_exec && st_q.op == OP_CALL |=> st_q.phase == PH_CALL2 &&
      st_q.stack[$past(st_q.sp)] == $past(st_q.pc) + 11'h001 ##1
      st_q.phase == PH_IDLE && st_q.pc == st_q.arg && $stable(st_q.flags)
  ) else $error("call sequence wrong");
  AST_CLR_MEM: assert property (
    in_exec && st_q.op == OP_ZERO_MEMORY_BYTE |=>
      st_q.dmem[$past(st_q.idx)] == ZERO_BYTE && $stable(st_q.flags)
  ) else $error("clear wrong");
  AST_NO_ANSWER_BUSY: assert property (
    st_q.phase != PH_IDLE |=> !pready
  ) else $error("answered while busy");

  COV_CALL: cover property (in_exec && st_q.op == OP_CALL ##2 pready);
  COV_OVERFLOW: cover property (in_exec && sum_v[10]);
  COV_CARRY_CHAIN: cover property (in_exec && st_q.op == OP_ADC &&
                                   st_q.flags.msb_out_flag);
  COV_BAD_ADDR: cover property (pslverr);

endmodule // alx_core

//--- rtl/alx_pkg.sv
// alx_pkg: constants and types for the add/logic/call/clear execution unit
package alx_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int DMEM_DEPTH = 16;
  localparam int DMEM_AW = 4;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_AW = 3;
  localparam int PC_W = 11;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_EXEC = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;
  localparam logic [7:0] ADDR_STACK = 8'h10;
  localparam logic [7:0] ADDR_DMEM = 8'h40;
  localparam logic [7:0] ADDR_DMEM_END = 8'h7C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int EXEC_OP_LSB = 0;
  localparam int EXEC_IDX_LSB = 8;
  localparam int EXEC_ARG_LSB = 16;
  localparam int STACK_SP_LSB = 16;
  localparam int FLAG_MSB_OUT = 0;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_NULL = 2;
  localparam int FLAG_EXCESS = 3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADC, OP_CARRY_SUM_INTO_MEMORY, OP_ADD, OP_ADD_IMM,
    OP_SUM_INTO_MEMORY, OP_AND, OP_AND_IMM,
    OP_BITWISE_CONJUNCTION_TO_MEMORY, OP_CALL, OP_ZERO_MEMORY_BYTE
  } alx_op_t;

  typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_CALL2} alx_phase_t;

  typedef struct packed {
    logic signed_excess_flag;
    logic result_null_flag;
    logic half_carry_flag;
    logic msb_out_flag;
  } alx_flags_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } alx_apb_rsp_t;

  typedef struct packed {
    alx_phase_t phase;
    alx_op_t op;
    logic [DMEM_AW-1:0] idx;
    logic [PC_W-1:0] arg;
    logic [7:0] acc;
    alx_flags_t flags;
    logic [PC_W-1:0] pc;
    logic [STACK_AW-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [DMEM_DEPTH-1:0][7:0] dmem;
    alx_apb_rsp_t rsp;
  } alx_state_t;
endpackage

//--- tb/tb_alx_core.sv
// tb_alx_core: self-checking bench for the add/and/call/clear unit
`timescale 1ns/1ps
module tb_alx_core;
  import alx_pkg::*;
  typedef struct packed {
    logic [3:0] op;
    logic [7:0] arg;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [3:0] fl;
    logic [7:0] eacc;
    logic [7:0] emem;
    logic [3:0] efl;
  } alx_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int total_checks = 0;
  alx_row_t rows [10];
  logic [7:0] ma;

  alx_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata));

  always #4 pclk = ~pclk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      n++;
      if (n > 50) begin
        fail_count++;
        $display("ERROR t=%0t no pready", $time);
        stop_test();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ex(input logic [3:0] op,
      input logic [3:0] idx, input logic [10:0] arg);
    return {5'h00, arg, 4'h0, idx, 4'h0, op};
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    // op, arg, acc, mem, flags in, acc, mem, flags expected
    rows = '{
      '{4'h1, 8'h00, 8'h7F, 8'h00, 4'h1, 8'h80, 8'h00, 4'hA},
      '{4'h2, 8'h00, 8'hFF, 8'h00, 4'h1, 8'hFF, 8'h00, 4'h7},
      '{4'h3, 8'h00, 8'h80, 8'h80, 4'h1, 8'h00, 8'h80, 4'hD},
      '{4'h4, 8'h08, 8'h08, 8'h55, 4'h0, 8'h10, 8'h55, 4'h2},
      '{4'h5, 8'h00, 8'h01, 8'h0F, 4'h1, 8'h01, 8'h10, 4'h2},
      '{4'h6, 8'h00, 8'hF0, 8'h0F, 4'hB, 8'h00, 8'h0F, 4'hF},
      '{4'h7, 8'h3C, 8'hF0, 8'h00, 4'h4, 8'h30, 8'h00, 4'h0},
      '{4'h8, 8'h00, 8'hAA, 8'hFF, 4'h3, 8'hAA, 8'hAA, 4'h3},
      '{4'hA, 8'h00, 8'h12, 8'h5A, 4'hF, 8'h12, 8'h00, 4'hF},
      '{4'h0, 8'h00, 8'h33, 8'h44, 4'h6, 8'h33, 8'h44, 4'h6}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_ACC, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, ADDR_STACK, 32'h0);
    chk(rd, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 10; i++) begin
      ma = ADDR_DMEM + 8'(4 * i);
      apb(1'b1, ADDR_ACC, {24'h0, rows[i].acc});
      apb(1'b1, ADDR_FLAGS, {28'h0, rows[i].fl});
      apb(1'b1, ma, {24'h0, rows[i].mem});
      apb(1'b1, ADDR_EXEC, ex(rows[i].op, 4'(i), {3'h0, rows[i].arg}));
      apb(1'b0, ADDR_ACC, 32'h0);
      chk(rd, {24'h0, rows[i].eacc});
      apb(1'b0, ma, 32'h0);
      chk(rd, {24'h0, rows[i].emem});
      apb(1'b0, ADDR_FLAGS, 32'h0);
      chk(rd, {28'h0, rows[i].efl});
    end
    $display("test instruction table done");
    // call from the top address: return address wraps to zero
    apb(1'b1, ADDR_FLAGS, 32'h5);
    apb(1'b1, ADDR_PC, 32'h7FF);
    apb(1'b1, ADDR_EXEC, ex(4'h9, 4'h0, 11'h2A5));
    apb(1'b0, ADDR_PC, 32'h0);
    chk(rd, 32'h2A5);
    apb(1'b0, ADDR_STACK, 32'h0);
    chk(rd, 32'h0001_0000);
    apb(1'b1, ADDR_EXEC, ex(4'h9, 4'h0, 11'h013));
    apb(1'b0, ADDR_STACK, 32'h0);
    chk(rd, 32'h0002_02A6);
    apb(1'b0, ADDR_PC, 32'h0);
    chk(rd, 32'h013);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(rd, 32'h5);
    $display("test call done");
    // read-only stack, unmapped and misaligned places
    apb(1'b1, ADDR_STACK, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_STACK, 32'h0);
    chk(rd, 32'h0002_02A6);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h41, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test refusals done");
    // reset in mid-run clears the call state
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_PC, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_STACK, 32'h0);
    chk(rd, 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule // tb_alx_core
